// file: common/flash_ctl_map.svh
`ifndef FLASH_CTL_MAP_SVH
`define FLASH_CTL_MAP_SVH
// command bytes
`define CMD_READ_ARRAY 8'hFF
`define CMD_READ_ID 8'h90
`define CMD_READ_STATUS 8'h70
`define CMD_CLEAR_STATUS 8'h50
`define CMD_ERASE_SETUP 8'h20
`define CMD_CONFIRM 8'hD0
`define CMD_SUSPEND 8'hB0
`define CMD_WRITE_SETUP 8'h40
`define CMD_WRITE_SETUP_ALT 8'h10
// identifier addresses
`define ID_ADDR_MFR 20'h0_0000
`define ID_ADDR_DEV 20'h0_0001
// status bit positions
`define SR_READY_BIT 7
`define SR_SUSPEND_BIT 6
`define SR_ERASE_ERR_BIT 5
`define SR_WRITE_ERR_BIT 4
`define SR_SUPPLY_ERR_BIT 3
// timing in ns; wake times from powerdown_reset_n rising
`define WAKE_TO_READ_NS 400
`define WAKE_TO_WRITE_NS 1000
`define CLK_PERIOD_NS 10
// strobe phase lengths in cycles
`define SETUP_CYCLES 4'h2
`define STROBE_CYCLES 4'h4
`define HOLD_CYCLES 4'h2
`endif

// file: common/flash_ctl_pkg.sv
package flash_ctl_pkg;
  typedef enum logic [2:0] {
    OP_READ,
    OP_WRITE,
    OP_POWERDOWN,
    OP_WAKE
  } op_e;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_HOLD,
    ST_SLEEP,
    ST_WAKE
  } state_e;
endpackage : flash_ctl_pkg

// file: common/flash_phase_if.sv
`timescale 1ns/100ps
`default_nettype none
// timer handshake between the sequencer and its phase counter
interface flash_phase_if;
  logic start;
  logic [15:0] length;
  logic done;
  modport owner (output start, output length, input done);
  modport timer (input start, input length, output done);
endinterface : flash_phase_if
`default_nettype wire

// file: core/flash_phase_timer.sv
`timescale 1ns/100ps
`default_nettype none
module flash_phase_timer (
  input wire logic clk_sys,
  input wire logic rst,
  flash_phase_if.timer ph
);
  logic [15:0] count;
  logic running;

  // loads on start, pulses done when the count reaches one
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      count <= 16'h0000;
      running <= 1'b0;
    end else if (ph.start) begin
      count <= ph.length;
      running <= 1'b1;
    end else if (running) begin
      count <= count - 16'h0001;
      if (count <= 16'h0001) begin
        running <= 1'b0;
      end
    end
  end

  // done is not masked by start, so the owner can chain phases without a loop
  assign ph.done = running && (count <= 16'h0001);
endmodule : flash_phase_timer
`default_nettype wire

// file: core/flash_host_ctl.sv
`timescale 1ns/100ps
`default_nettype none
`include "flash_ctl_map.svh"
// Contract
// - host writes read-mode command before reads
// - drive read only with ce,oe low
// - never oe and we low together
// - erase/write needs setup then confirm
// - wait wake-to-read before first read
// - wait wake-to-write before any write
// - data latched on write strobe rise
// - FFH selects array read
module flash_host_ctl #(
  parameter int ADDR_W = 20,
  parameter int WAKE_READ_CYC = (`WAKE_TO_READ_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int WAKE_WRITE_CYC = (`WAKE_TO_WRITE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic req_valid,
  output logic req_ready,
  input wire flash_ctl_pkg::op_e req_op,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [7:0] req_wdata,
  output logic rsp_valid,
  output logic [7:0] rsp_rdata,
  output logic busy,
  output logic write_allowed,
  output logic [ADDR_W-1:0] addr,
  output logic chip_select_n,
  output logic output_drive_n,
  output logic write_strobe_n,
  output logic powerdown_reset_n,
  input wire logic [7:0] data_lines_in,
  output logic [7:0] data_lines_out,
  output logic data_lines_oe,
  input wire logic ready_busy_n
);
  flash_phase_if ph ();
  flash_phase_timer u_timer (
    .clk_sys(clk_sys),
    .rst(rst),
    .ph(ph)
  );

  flash_ctl_pkg::state_e state;
  flash_ctl_pkg::state_e next_state;
  flash_ctl_pkg::op_e op;
  flash_ctl_pkg::op_e eff_op;
  logic [15:0] wake_count;
  logic [7:0] din_meta;
  logic [7:0] din_sync;
  logic rb_meta;
  logic rb_sync;
  logic wrote_setup;

  // sizes a phase length for the timer
  function automatic logic [15:0] len16(input int n);
    len16 = (n < 1) ? 16'h0001 : 16'(n);
  endfunction : len16

  // is this byte a two-write setup command
  function automatic logic is_setup(input logic [7:0] b);
    is_setup = (b == `CMD_ERASE_SETUP) || (b == `CMD_WRITE_SETUP) ||
      (b == `CMD_WRITE_SETUP_ALT);
  endfunction : is_setup

  // two-flop synchronisers on pins
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      din_meta <= 8'h00;
      din_sync <= 8'h00;
      rb_meta <= 1'b1;
      rb_sync <= 1'b1;
    end else begin
      din_meta <= data_lines_in;
      din_sync <= din_meta;
      rb_meta <= ready_busy_n;
      rb_sync <= rb_meta;
    end
  end
  assign busy = !rb_sync;

  // next state selection
  always_comb begin
    next_state = state;
    case (state)
      flash_ctl_pkg::ST_IDLE: begin
        if (req_valid && req_ready) begin
          if (req_op == flash_ctl_pkg::OP_POWERDOWN) begin
            next_state = flash_ctl_pkg::ST_SLEEP;
          end else if (req_op == flash_ctl_pkg::OP_WAKE) begin
            next_state = flash_ctl_pkg::ST_IDLE;
          end else begin
            next_state = flash_ctl_pkg::ST_SETUP;
          end
        end
      end
      flash_ctl_pkg::ST_SETUP: begin
        if (ph.done) begin
          next_state = flash_ctl_pkg::ST_STROBE;
        end
      end
      flash_ctl_pkg::ST_STROBE: begin
        if (ph.done) begin
          next_state = flash_ctl_pkg::ST_HOLD;
        end
      end
      flash_ctl_pkg::ST_HOLD: begin
        if (ph.done) begin
          next_state = flash_ctl_pkg::ST_IDLE;
        end
      end
      flash_ctl_pkg::ST_SLEEP: begin
        if (req_valid && req_op == flash_ctl_pkg::OP_WAKE) begin
          next_state = flash_ctl_pkg::ST_WAKE;
        end
      end
      flash_ctl_pkg::ST_WAKE: begin
        if (wake_count >= len16(WAKE_READ_CYC)) begin
          next_state = flash_ctl_pkg::ST_IDLE;
        end
      end
      default: next_state = flash_ctl_pkg::ST_IDLE;
    endcase
  end

  // request accepted when idle, or a wake while asleep; writes also wait for wake-to-write
  assign req_ready = (state == flash_ctl_pkg::ST_IDLE) &&
    (write_allowed || req_op != flash_ctl_pkg::OP_WRITE) ||
    (state == flash_ctl_pkg::ST_SLEEP && req_op == flash_ctl_pkg::OP_WAKE);

  // op of the cycle being started; the captured op lags the accept edge by one
  assign eff_op = (state == flash_ctl_pkg::ST_IDLE) ? req_op : op;

  // phase timer starts on each phase entry
  always_comb begin
    ph.start = 1'b0;
    ph.length = len16(`SETUP_CYCLES);
    if (next_state != state) begin
      case (next_state)
        flash_ctl_pkg::ST_SETUP: begin
          ph.start = 1'b1;
          ph.length = len16(`SETUP_CYCLES);
        end
        flash_ctl_pkg::ST_STROBE: begin
          ph.start = 1'b1;
          ph.length = len16(`STROBE_CYCLES);
        end
        flash_ctl_pkg::ST_HOLD: begin
          ph.start = 1'b1;
          ph.length = len16(`HOLD_CYCLES);
        end
        default: ph.start = 1'b0;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= flash_ctl_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // captured request
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      op <= flash_ctl_pkg::OP_READ;
      addr <= '0;
      data_lines_out <= 8'h00;
    end else if (state == flash_ctl_pkg::ST_IDLE && req_valid && req_ready) begin
      op <= req_op;
      addr <= req_addr;
      data_lines_out <= req_wdata;
    end
  end

  // tracks a setup write still waiting for its confirm or data write
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wrote_setup <= 1'b0;
    end else if (state == flash_ctl_pkg::ST_SLEEP) begin
      wrote_setup <= 1'b0;
    end else if (state == flash_ctl_pkg::ST_HOLD && ph.done &&
        op == flash_ctl_pkg::OP_WRITE) begin
      wrote_setup <= !wrote_setup && is_setup(data_lines_out);
    end
  end

  // wake interval counter since powerdown_reset_n rose
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wake_count <= 16'h0000;
    end else if (state == flash_ctl_pkg::ST_SLEEP) begin
      wake_count <= 16'h0000;
    end else if (wake_count != 16'hFFFF) begin
      wake_count <= wake_count + 16'h0001;
    end
  end
  assign write_allowed = wake_count >= len16(WAKE_WRITE_CYC);

  // pin drive; oe and we never low together
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      chip_select_n <= 1'b1;
      output_drive_n <= 1'b1;
      write_strobe_n <= 1'b1;
      powerdown_reset_n <= 1'b1;
      data_lines_oe <= 1'b0;
    end else begin
      powerdown_reset_n <= (next_state != flash_ctl_pkg::ST_SLEEP);
      chip_select_n <= !(next_state == flash_ctl_pkg::ST_SETUP ||
        next_state == flash_ctl_pkg::ST_STROBE || next_state == flash_ctl_pkg::ST_HOLD);
      output_drive_n <= !(op == flash_ctl_pkg::OP_READ &&
        (next_state == flash_ctl_pkg::ST_STROBE));
      write_strobe_n <= !(op == flash_ctl_pkg::OP_WRITE &&
        next_state == flash_ctl_pkg::ST_STROBE);
      data_lines_oe <= eff_op == flash_ctl_pkg::OP_WRITE &&
        (next_state == flash_ctl_pkg::ST_SETUP || next_state == flash_ctl_pkg::ST_STROBE ||
        next_state == flash_ctl_pkg::ST_HOLD);
    end
  end

  // read data sampled at end of strobe
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= 8'h00;
    end else begin
      rsp_valid <= state == flash_ctl_pkg::ST_HOLD && ph.done;
      if (state == flash_ctl_pkg::ST_STROBE && ph.done && op == flash_ctl_pkg::OP_READ) begin
        rsp_rdata <= din_sync;
      end
    end
  end

  a_no_oe_we_low: assert property (@(posedge clk_sys) disable iff (rst)
    !(!output_drive_n && !write_strobe_n)) else $error("oe and we low together");
  a_read_gating: assert property (@(posedge clk_sys) disable iff (rst)
    !output_drive_n |-> !chip_select_n && write_strobe_n && powerdown_reset_n)
    else $error("read drive without proper pins");
  a_wake_write: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(write_strobe_n) |-> write_allowed) else $error("write before wake time");
  a_wake_read: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(powerdown_reset_n) |-> output_drive_n [*8]) else $error("read too early");
  a_data_held: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(write_strobe_n) |-> data_lines_oe && $stable(data_lines_out))
    else $error("data not held at strobe rise");
  a_setup_pair: assert property (@(posedge clk_sys) disable iff (rst)
    !output_drive_n |-> !wrote_setup) else $error("read between setup and confirm");
  a_sleep_quiet: assert property (@(posedge clk_sys) disable iff (rst)
    !powerdown_reset_n |-> chip_select_n && output_drive_n && write_strobe_n &&
    !data_lines_oe) else $error("bus active in powerdown");
endmodule : flash_host_ctl
`default_nettype wire

// file: tb/flash_dev_model.sv
`timescale 1ns/100ps
`default_nettype none
module flash_dev_model #(
  parameter logic [7:0] MFR_CODE = 8'h5a, // arbitrary value
  parameter logic [7:0] DEV_CODE = 8'hc3, // arbitrary value
  parameter int BUSY_NS = 500
) (
  input wire logic [19:0] addr,
  input wire logic chip_select_n,
  input wire logic output_drive_n,
  input wire logic write_strobe_n,
  input wire logic powerdown_reset_n,
  input wire logic [7:0] host_data,
  input wire logic host_oe,
  output logic [7:0] data_lines,
  output logic ready_busy_n
);
  logic [7:0] mem [int];
  logic [1:0] mode = 2'h0; // 0 array, 1 id, 2 status
  logic [1:0] pend = 2'h0; // 1 byte write armed, 2 erase armed
  logic susp = 1'b0; // erase held by suspend
  logic erasing = 1'b0;
  logic [7:0] rd_val;
  logic [7:0] held = 8'h00;
  logic drive;
  int gen = 0; // bumped by powerdown so a running op is dropped
  initial ready_busy_n = 1'b1;
  // drive only on a clean read cycle
  assign drive = !chip_select_n && !output_drive_n && write_strobe_n && powerdown_reset_n;
  // read mux per mode
  always @* begin
    if (mode == 2'h1) rd_val = addr[0] ? DEV_CODE : MFR_CODE;
    else if (mode == 2'h2) rd_val = {ready_busy_n, susp, 6'h00};
    else rd_val = mem.exists(addr) ? mem[addr] : 8'hff;
  end
  // undriven bus shows the inverse of its last level
  always @* if (host_oe) held = host_data; else if (drive) held = rd_val;
  assign data_lines = host_oe ? host_data : drive ? rd_val : ~held;
  // background sequencer op
  task automatic run(input logic erase, input logic [19:0] a, input logic [7:0] d);
    int g;
    g = gen;
    erasing = erase;
    ready_busy_n = 1'b0;
    #(BUSY_NS);
    // a suspended erase sits here until resume, then runs a further full BUSY_NS
    while (susp && g == gen) begin
      wait (!susp || g != gen);
      #(BUSY_NS);
    end
    if (g == gen) begin
      if (erase) foreach (mem[k]) if (k[19:16] == a[19:16]) mem[k] = 8'hff;
      if (!erase) mem[a] = d;
      ready_busy_n = 1'b1;
      erasing = 1'b0;
    end
  endtask : run
  // command latch on strobe rise
  always @(posedge write_strobe_n) begin
    if (!chip_select_n && powerdown_reset_n === 1'b1) begin
      if (!ready_busy_n) begin
        // only a suspend during an erase is heard while the sequencer runs
        if (erasing && data_lines == 8'hb0) begin
          susp = 1'b1;
          ready_busy_n = 1'b1;
          mode = 2'h2;
        end
      end else if (susp && data_lines == 8'hd0) begin
        susp = 1'b0;
        ready_busy_n = 1'b0;
        mode = 2'h2;
      end else if (pend == 2'h1) begin
        pend = 2'h0;
        mode = 2'h2;
        fork run(1'b0, addr, data_lines); join_none
      end else if (pend == 2'h2 && data_lines == 8'hd0) begin
        pend = 2'h0;
        mode = 2'h2;
        fork run(1'b1, addr, 8'hff); join_none
      end else begin
        pend = 2'h0;
        case (data_lines)
          8'hff: mode = 2'h0;
          8'h90: mode = 2'h1;
          8'h70: mode = 2'h2;
          8'h40, 8'h10: pend = 2'h1;
          8'h20: pend = 2'h2;
          default: ; // stray byte leaves the array alone
        endcase
      end
    end
  end
  // deep powerdown
  always @(negedge powerdown_reset_n) begin
    gen++;
    ready_busy_n = 1'b1;
    mode = 2'h0;
    pend = 2'h0;
    susp = 1'b0;
    erasing = 1'b0;
  end
endmodule : flash_dev_model
`default_nettype wire

// file: tb/test_flash_host_ctl.sv
`timescale 1ns/100ps
`default_nettype none
module test_flash_host_ctl;
  logic clk_sys, rst, req_valid, req_ready, rsp_valid, busy, write_allowed;
  logic chip_select_n, output_drive_n, write_strobe_n, powerdown_reset_n;
  logic data_lines_oe, ready_busy_n;
  flash_ctl_pkg::op_e req_op;
  logic [19:0] req_addr, addr;
  logic [7:0] req_wdata, rsp_rdata, data_lines_in, data_lines_out;
  int failures = 0;
  int samples_checked = 0;
  flash_host_ctl #(.WAKE_READ_CYC(2), .WAKE_WRITE_CYC(4)) u_dut (
    .clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
    .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .busy(busy), .write_allowed(write_allowed), .addr(addr),
    .chip_select_n(chip_select_n), .output_drive_n(output_drive_n),
    .write_strobe_n(write_strobe_n), .powerdown_reset_n(powerdown_reset_n),
    .data_lines_in(data_lines_in), .data_lines_out(data_lines_out),
    .data_lines_oe(data_lines_oe), .ready_busy_n(ready_busy_n));
  flash_dev_model u_flash (
    .addr(addr), .chip_select_n(chip_select_n), .output_drive_n(output_drive_n),
    .write_strobe_n(write_strobe_n), .powerdown_reset_n(powerdown_reset_n),
    .host_data(data_lines_out), .host_oe(data_lines_oe), .data_lines(data_lines_in),
    .ready_busy_n(ready_busy_n));
  // clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wait_for(ref logic sig, input logic val);
    int n;
    n = 0;
    while (sig !== val && n < 1000) begin
      @(negedge clk_sys);
      n++;
    end
    check({7'h00, sig}, {7'h00, val});
  endtask : wait_for
  // one request, held until taken, then its response for a read or write
  task automatic op(input flash_ctl_pkg::op_e o, input logic [19:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    req_op = o;
    req_addr = a;
    req_wdata = d;
    req_valid = 1'b1;
    #1;
    wait_for(req_ready, 1'b1);
    @(posedge clk_sys);
    @(negedge clk_sys);
    req_valid = 1'b0;
    if (o == flash_ctl_pkg::OP_READ || o == flash_ctl_pkg::OP_WRITE) wait_for(rsp_valid, 1'b1);
  endtask : op
  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    op(flash_ctl_pkg::OP_WRITE, a, d);
  endtask : wr
  task automatic rd(input logic [19:0] a, input logic [7:0] exp);
    op(flash_ctl_pkg::OP_READ, a, 8'h00);
    check(rsp_rdata, exp);
  endtask : rd
  task automatic t_reset;
    check({4'h0, chip_select_n, output_drive_n, write_strobe_n, powerdown_reset_n}, 8'h0f);
    check({7'h00, write_allowed}, 8'h00);
    repeat (8) @(negedge clk_sys);
    check({7'h00, write_allowed}, 8'h01);
    rd(20'h0_0123, 8'hff);
    $display("reset test done");
  endtask : t_reset
  task automatic t_write;
    wr(20'h5_0000, 8'h10);
    wr(20'h5_0000, 8'h3c);
    repeat (3) @(negedge clk_sys);
    check({chip_select_n, busy, 6'h00}, 8'hc0);
    wait_for(busy, 1'b0);
    wr(20'h3_0010, 8'h40);
    wr(20'h3_0010, 8'ha5);
    wait_for(busy, 1'b0);
    wr(20'h0_0000, 8'hff);
    rd(20'h5_0000, 8'h3c);
    rd(20'h3_0010, 8'ha5);
    wr(20'h5_0000, 8'h00);
    rd(20'h5_0000, 8'h3c);
    $display("write test done");
  endtask : t_write
  task automatic t_modes;
    wr(20'h0_0000, 8'h90);
    rd(20'h0_0000, 8'h5a);
    rd(20'h0_0001, 8'hc3);
    wr(20'h0_0000, 8'h70);
    rd(20'h0_0000, 8'h80);
    $display("mode test done");
  endtask : t_modes
  task automatic t_erase;
    wr(20'h3_0010, 8'h20);
    wr(20'h3_0010, 8'hd0);
    repeat (3) @(negedge clk_sys);
    check({7'h00, busy}, 8'h01);
    wr(20'h0_0000, 8'hb0);
    rd(20'h0_0000, 8'hc0);
    wait_for(busy, 1'b0);
    wr(20'h0_0000, 8'hff);
    rd(20'h5_0000, 8'h3c);
    rd(20'h3_0010, 8'ha5);
    wr(20'h3_0010, 8'hd0);
    repeat (3) @(negedge clk_sys);
    check({7'h00, busy}, 8'h01);
    wait_for(busy, 1'b0);
    wr(20'h0_0000, 8'hff);
    rd(20'h3_0010, 8'hff);
    rd(20'h5_0000, 8'h3c);
    $display("erase test done");
  endtask : t_erase
  task automatic t_abort;
    wr(20'h1_0000, 8'h40);
    wr(20'h1_0000, 8'h77);
    op(flash_ctl_pkg::OP_POWERDOWN, 20'h0_0000, 8'h00);
    check({powerdown_reset_n, ready_busy_n, 6'h00}, 8'h40);
    op(flash_ctl_pkg::OP_WAKE, 20'h0_0000, 8'h00);
    wait_for(write_allowed, 1'b1);
    rd(20'h5_0000, 8'h3c);
    wr(20'h0_0000, 8'h70);
    rd(20'h0_0000, 8'h80);
    $display("powerdown test done");
  endtask : t_abort
  // read drive and write strobe must never overlap
  always @(negedge clk_sys) begin
    if (!rst && output_drive_n === 1'b0 && write_strobe_n === 1'b0) check(8'h01, 8'h00);
  end
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run
  // watchdog
  initial begin
    #200000;
    failures++;
    complete_run;
  end
  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req_op = flash_ctl_pkg::OP_READ;
    req_addr = 20'h0_0000;
    req_wdata = 8'h00;
    repeat (16) @(negedge clk_sys);
    rst = 1'b0;
    t_reset;
    t_write;
    t_modes;
    t_erase;
    t_abort;
    complete_run;
  end
endmodule : test_flash_host_ctl
`default_nettype wire
